// ==== drv_pkg.sv ====
// Purpose: Shared constants and types for the two-wire octal driver target
// Assumes: 50 MHz system clock
// Notes:   Address layout and the latch reset value live here
package drv_pkg;

    // Address layout: fixed upper four bits, three strapped bits
    localparam logic [3:0] addr_fixed_bits  = 4'h7;
    localparam int         addr_width       = 7;
    localparam int         addr_strap_width = 3;
    localparam int         bits_per_byte    = 8;
    localparam logic [3:0] ack_bit_index    = 4'h8;

    // Latch reset: all outputs driven low (on)
    localparam logic [7:0] latch_reset      = 8'h00;
    localparam logic       write_direction  = 1'b0;

    // Receiver states
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_data,
        st_data_ack,
        st_ignore
    } rx_state_t;

    // Synchronised bus pins
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

endpackage

// ==== drv_sync.sv ====
// Purpose: Two flip-flop synchroniser for a group of pins
// Assumes: Inputs asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module drv_sync #(
    parameter int width      = 2,
    parameter logic [31:0] rst_value = 32'hffffffff
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Data
    input  wire logic [width-1:0] async_in,
    output var  logic [width-1:0] sync_out
);

    logic [width-1:0] stage1;

    // Elaboration check: the reset word holds at most 32 bits
    if (width < 1 || width > 32) begin : g_width_check
        $error("drv_sync: width out of range");
    end

    // Two-stage capture
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1   <= rst_value[width-1:0];
            sync_out <= rst_value[width-1:0];
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule
`default_nettype wire

// ==== drv_target.sv ====
// Purpose: Write-only two-wire target driving eight open-drain outputs
// Assumes: Bus pins oversampled by a 50 MHz clock, bus at most 400 kHz
// Notes:   Only write transfers accepted; reads are ignored
//
// Summary of operation
// - A falling data line while the clock line is high is a start that readies the address decoder.
// - A rising data line while the clock line is high is a stop that returns the target to idle.
// - Seven address bits are shifted in after the start and compared with the own address.
// - The upper four address bits are fixed and the lower three come from the select pins, giving 38h to 3Fh.
// - Unconnected select pins read as one because of their pull-ups.
// - When addressed the target holds the data line low through the ninth clock of every byte.
// - A one in a data bit releases the matching output and a zero drives it low.
// - After reset all eight outputs are driven low.
`timescale 1ns/10ps
`default_nettype none
module drv_target #(
    parameter int out_count = 8
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // Address straps
    input  wire logic [2:0]           addr_select_pins,
    // Two-wire bus
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output var  logic                 sda_out,
    output var  logic                 sda_oe,
    // Driver outputs
    output var  logic [out_count-1:0] open_drain_drive_outputs,
    output var  logic [out_count-1:0] drive_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    drv_pkg::bus_pins_t         pins;
    drv_pkg::bus_pins_t         pins_q;
    logic [2:0]                 straps;
    drv_pkg::rx_state_t         state;
    logic [3:0]                 bit_cnt;
    logic [7:0]                 shift;
    logic [out_count-1:0]       output_drive_latch;
    logic                       start_det;
    logic                       stop_det;
    logic                       scl_rise;
    logic                       scl_fall;
    logic [6:0]                 own_addr;

    // Elaboration check: the latch is loaded from one received byte
    if (out_count != drv_pkg::bits_per_byte) begin : g_count_check
        $error("drv_target: out_count must be 8");
    end

    // Default width and all-ones reset match the idle bus
    drv_sync u_bus_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins)
    );

    // Pull-ups mean an open strap resets and reads as one
    drv_sync #(.width(3)) u_strap_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in (addr_select_pins),
        .sync_out (straps)
    );

    // Own address from fixed bits and straps
    assign own_addr = {drv_pkg::addr_fixed_bits, straps};

    ////////////////////////////////////////////////////////////////////////
    // Bus event detection

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pins_q <= '1;
        end else begin
            pins_q <= pins;
        end
    end

    assign start_det = pins_q.scl && pins.scl && pins_q.sda && !pins.sda;
    assign stop_det  = pins_q.scl && pins.scl && !pins_q.sda && pins.sda;
    assign scl_rise  = !pins_q.scl && pins.scl;
    assign scl_fall  = pins_q.scl && !pins.scl;

    ////////////////////////////////////////////////////////////////////////
    // Receive state machine

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state   <= drv_pkg::st_idle;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (start_det) begin
            // Repeated start also lands here
            state   <= drv_pkg::st_addr;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (stop_det) begin
            state   <= drv_pkg::st_idle;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                drv_pkg::st_addr, drv_pkg::st_data: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], pins.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == drv_pkg::ack_bit_index) begin
                        bit_cnt <= 4'h0;
                        if (state == drv_pkg::st_data) begin
                            state <= drv_pkg::st_data_ack;
                        end else if (shift[7:1] == own_addr
                                     && shift[0] == drv_pkg::write_direction) begin
                            state <= drv_pkg::st_addr_ack;
                        end else begin
                            state <= drv_pkg::st_ignore;
                        end
                    end
                end
                drv_pkg::st_addr_ack, drv_pkg::st_data_ack: begin
                    // Ninth clock ends on its falling edge
                    if (scl_fall) begin
                        state <= drv_pkg::st_data;
                    end
                end
                default: begin
                    // Idle and ignore wait for the next start
                    state <= state;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge drive

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= (state == drv_pkg::st_addr_ack || state == drv_pkg::st_data_ack)
                       && !(scl_fall || start_det || stop_det);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch

    // Latch on the falling edge closing the data acknowledge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            output_drive_latch <= drv_pkg::latch_reset;
        end else if (state == drv_pkg::st_data_ack && scl_fall && !start_det && !stop_det) begin
            output_drive_latch <= shift;
        end
    end

    // Zero bit pulls low, one bit releases
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            open_drain_drive_outputs <= '0;
            drive_oe                 <= '1;
        end else begin
            open_drain_drive_outputs <= '0;
            drive_oe                 <= ~output_drive_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_ack_low_ninth: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_addr_ack && !scl_fall && !start_det && !stop_det) |=> sda_oe)
        else $error("ack not driven");
    a_ignore_release: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_ignore) |=> !sda_oe)
        else $error("sda driven while ignoring");
    a_stop_idle: assert property (@(posedge clock) disable iff (!arst_n)
        (stop_det && !start_det) |=> state == drv_pkg::st_idle)
        else $error("stop not honoured");
    a_start_addr: assert property (@(posedge clock) disable iff (!arst_n)
        start_det |=> (state == drv_pkg::st_addr && bit_cnt == 4'h0))
        else $error("start not honoured");
    a_latch_drive: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_data_ack && scl_fall && !start_det && !stop_det)
        |=> ##1 drive_oe == ~$past(shift, 2))
        else $error("outputs do not follow byte");
    a_latch_hold: assert property (@(posedge clock) disable iff (!arst_n)
        (state != drv_pkg::st_data_ack) |=> $stable(output_drive_latch))
        else $error("latch changed outside ack");
    a_addr_match: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_addr && scl_fall && bit_cnt == drv_pkg::ack_bit_index
         && !start_det && !stop_det && shift[7:1] != own_addr)
        |=> state == drv_pkg::st_ignore)
        else $error("foreign address accepted");
    a_read_refused: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_addr && scl_fall && bit_cnt == drv_pkg::ack_bit_index
         && !start_det && !stop_det && shift[0])
        |=> state == drv_pkg::st_ignore)
        else $error("read accepted");

    // Line must already be low whenever the ninth clock is high
    a_ack_held: assert property (@(posedge clock) disable iff (!arst_n)
        ((state == drv_pkg::st_addr_ack || state == drv_pkg::st_data_ack) && pins.scl) |-> sda_oe)
        else $error("ack released during ninth clock");
    a_oe_only_ack: assert property (@(posedge clock) disable iff (!arst_n)
        sda_oe |-> (state == drv_pkg::st_addr_ack || state == drv_pkg::st_data_ack))
        else $error("data line driven outside ack");
    a_bit_count_range: assert property (@(posedge clock) disable iff (!arst_n)
        (state == drv_pkg::st_addr || state == drv_pkg::st_data) |-> bit_cnt <= drv_pkg::ack_bit_index)
        else $error("bit counter past byte end");

endmodule
`default_nettype wire

// ==== drv_master.sv ====
// Purpose: Bus master model for the two-wire octal driver target
// Assumes: Data line pull-up is resolved in the bench
// Notes:   Each bus phase lasts ten system clocks
`timescale 1ns/10ps
`default_nettype none
module drv_master (
    // Clock
    input  wire logic clock,
    // Two-wire bus
    input  wire logic sda_wire,
    output var  logic scl,
    output var  logic sda_low
);
    localparam int half = 10;

    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Wait n edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One clock pulse; seen turns x if the line moves while clock is high
    task automatic pulse(input logic b, output logic seen);
        sda_low = ~b;
        tick(half);
        scl = 1'b1;
        tick(half / 2);
        seen = sda_wire;
        tick(half / 2);
        if (sda_wire !== seen) seen = 1'bx;
        scl = 1'b0;
        tick(2);
    endtask

    // Start, or repeated start when the clock is low
    task automatic start();
        sda_low = 1'b0;
        tick(half);
        scl = 1'b1;
        tick(half);
        sda_low = 1'b1;
        tick(half);
        scl = 1'b0;
        tick(2);
    endtask

    // Stop, also used to abort after a missing acknowledge
    task automatic stop();
        sda_low = 1'b1;
        tick(half);
        scl = 1'b1;
        tick(half);
        sda_low = 1'b0;
        tick(half);
    endtask

    // Send n bits MSB first; a full byte gets the acknowledge pulse
    task automatic send(input logic [7:0] v, input int n, output logic lvl);
        logic dummy;
        for (int i = 0; i < n; i++) begin
            pulse(v[7-i], dummy);
        end
        lvl = 1'b1;
        if (n == 8) pulse(1'b1, lvl);
    endtask
endmodule
`default_nettype wire

// ==== i2c_octal_open_drain_driver_bench.sv ====
// Purpose: Self-checking bench for the two-wire octal driver target
// Assumes: Master model paces the bus at ten clocks a phase
// Notes:   Expected output enables, the inverse of the latched byte, are tracked in exp_oe
`timescale 1ns/10ps
`default_nettype none
module i2c_octal_open_drain_driver_bench;
    logic       clock;
    logic       arst_n;
    logic [2:0] straps;
    logic       scl;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe;
    logic       sda_wire;
    logic [7:0] q;
    logic [7:0] drive_oe;
    logic [7:0] exp_oe;
    logic       lvl;
    int         bad_count;
    int         n_checks;

    // Pulled-up data wire
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
    always #10 clock = ~clock;

    drv_target u_dut (.clock(clock), .arst_n(arst_n), .addr_select_pins(straps), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .open_drain_drive_outputs(q),
        .drive_oe(drive_oe));
    drv_master u_master (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Full frame: address with rw bit, nb data bytes, stop
    task automatic frame(input logic [6:0] adr, input logic rw, input logic [7:0] d0,
                         input logic [7:0] d1, input int nb, input logic ok);
        u_master.start();
        u_master.send({adr, rw}, 8, lvl);
        check({7'h00, lvl}, {7'h00, ~ok});
        for (int i = 0; i < nb; i++) begin
            u_master.send(i == 0 ? d0 : d1, 8, lvl);
            check({7'h00, lvl}, {7'h00, ~ok});
            if (ok) exp_oe = ~(i == 0 ? d0 : d1);
        end
        u_master.stop();
        u_master.tick(4);
        check(drive_oe, exp_oe);
        check(q, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        straps = 3'h7;
        bad_count = 0;
        n_checks = 0;
        exp_oe = 8'hff;
        u_master.tick(20);
        arst_n = 1'b1;
        u_master.tick(6);
        check(drive_oe, 8'hff);
        check({7'h00, sda_oe}, 8'h00);
        check({7'h00, sda_out}, 8'h00);
        $display("test reset done");
        frame(7'h3f, 1'b0, 8'ha5, 8'h3c, 2, 1'b1);
        $display("test open straps and overwrite done");
        for (int s = 0; s < 8; s++) begin
            straps = s[2:0];
            u_master.tick(4);
            frame({4'h7, s[2:0]}, 1'b0, 8'h5a ^ {s[2:0], 5'h00}, 8'h00, 1, 1'b1);
        end
        $display("test all straps done");
        frame(7'h3e, 1'b0, 8'h00, 8'h00, 1, 1'b0);
        frame(7'h3f, 1'b1, 8'h00, 8'h00, 0, 1'b0);
        $display("test refused frames done");
        u_master.start();
        u_master.send(8'h7e, 8, lvl);
        u_master.send(8'h0f, 5, lvl);
        u_master.stop();
        u_master.tick(4);
        check(drive_oe, exp_oe);
        $display("test partial byte done");
        u_master.start();
        u_master.send(8'h72, 8, lvl);
        check({7'h00, lvl}, 8'h01);
        frame(7'h3f, 1'b0, 8'h81, 8'h00, 1, 1'b1);
        $display("test repeated start done");
        arst_n = 1'b0;
        u_master.tick(2);
        check(drive_oe, 8'hff);
        arst_n = 1'b1;
        $display("test second reset done");
        end_sim();
    end

    // Watchdog against a hung run
    initial begin
        repeat (50000) @(posedge clock);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
